// ===== rtl/pcm_ctrl.sv
// pll clock mode control: lock flag, clock select, stop handling, bus slave
//
// Function
// - with self bandwidth set, each freq_settled change raises an interrupt request.
// - lock_change_flag sets on every change; lock_irq_enable only gates the request.
// - self bandwidth clear suppresses pll requests; lock_change_flag reads 0.
// - base_clk_sel may select the vco clock even while unsettled.
// - wait mode leaves oscillator, pll, selection and outputs unchanged.
// - stop without oscillator keep halts oscillator, pll and holds outputs low.
// - stop while vco drives output clears base_clk_sel, falling back to oscillator.
// - after stop the oscillator half drives output; base_clk_sel stays clear.
// - stop with oscillator keep shuts pll but oscillator keeps running.
// - break_clear_en high lets flag clearing work in break; stays cleared.
// - break_clear_en low protects lock_change_flag from accesses during break.
// - outside protected break, any access to pll_ctrl_reg clears lock_change_flag.
// - output clock is the vco clock halved if selected, else oscillator halved.
`timescale 1ns/1ps
module pcm_ctrl
    import pcm_pkg::*;
#(
    parameter int ADDR_W = PCM_ADDR_W,
    parameter int DATA_W = PCM_DATA_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // system module
    input wire logic stop_mode,
    input wire logic stop_osc_keep,
    input wire logic break_state,
    input wire logic break_clear_en,
    // analog pll pins
    input wire logic freq_settled_pin,
    input wire logic divided_vco_clk,
    // clock generator outputs
    output logic osc_run,
    output logic pll_run,
    output logic base_clk_out,
    output logic clkgen_irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    initial begin
        if (ADDR_W != PCM_ADDR_W) begin
            $error("pcm_ctrl: ADDR_W must match the register map width");
        end
        if (DATA_W < 8) begin
            $error("pcm_ctrl: DATA_W must hold an 8-bit register");
        end
        if (PCM_EV_FALLBACK_BIT >= PCM_EV_W || PCM_EV_LOCK_BIT >= PCM_EV_W) begin
            $error("pcm_ctrl: event bits must fit the status width");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic settled_s;
    logic vco_s;
    logic settled_prev_r;
    logic settled_prev_nxt;
    logic vco_prev_r;
    logic vco_prev_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    pcm_ctrl_s ctrl_r;
    pcm_ctrl_s ctrl_nxt;
    logic auto_r;
    logic auto_nxt;
    logic [PCM_EV_W-1:0] ev_stat_r;
    logic [PCM_EV_W-1:0] ev_stat_nxt;
    logic [PCM_EV_W-1:0] ev_en_r;
    logic [PCM_EV_W-1:0] ev_en_nxt;
    logic [PCM_EV_W-1:0] ev_set;
    pcm_mode_e mode_r;
    pcm_mode_e mode_nxt;
    logic clk_half_r;
    logic clk_half_nxt;
    logic irq_r;
    logic irq_nxt;
    logic osc_run_r;
    logic osc_run_nxt;
    logic pll_run_r;
    logic pll_run_nxt;
    logic lock_edge;
    logic wr_hit;
    logic rd_hit;
    logic ctrl_touch;
    logic clr_ok;
    logic fallback;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // the vco clock is sampled, so it must run well below half of clk
    pcm_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({freq_settled_pin, divided_vco_clk}),
        .q({settled_s, vco_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, then the access completes

    assign wr_hit = ack_r & avs_write;
    assign rd_hit = ack_r & avs_read;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata = rdata_r;

    always_comb begin
        ack_nxt = (avs_read | avs_write) & ~ack_r;
        rdata_nxt = rdata_r;
        if (avs_read && !ack_r) begin
            rdata_nxt = '0;
            unique case (avs_address)
                PCM_OFF_PLL_CTRL: begin
                    rdata_nxt[PCM_CTL_IRQ_EN_BIT] = ctrl_r.lock_irq_enable;
                    rdata_nxt[PCM_CTL_FLAG_BIT] = ctrl_r.lock_change_flag & auto_r;
                    rdata_nxt[PCM_CTL_PLL_EN_BIT] = ctrl_r.pll_enable;
                    rdata_nxt[PCM_CTL_BCS_BIT] = ctrl_r.base_clk_sel;
                end
                PCM_OFF_BW_CTRL: begin
                    rdata_nxt[PCM_BW_AUTO_BIT] = auto_r;
                    rdata_nxt[PCM_BW_SETTLED_BIT] = settled_s & auto_r;
                end
                PCM_OFF_IRQ_STAT: begin
                    rdata_nxt[PCM_EV_W-1:0] = ev_stat_r;
                end
                PCM_OFF_IRQ_EN: begin
                    rdata_nxt[PCM_EV_W-1:0] = ev_en_r;
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lock flag and control register

    assign lock_edge = settled_s ^ settled_prev_r;
    // limitation: a lock change landing between a read's two edges is cleared unseen,
    // only the sticky status bit keeps a record of it
    assign ctrl_touch = (rd_hit | wr_hit) && (avs_address == PCM_OFF_PLL_CTRL);
    // a debugger read in break must not eat a pending lock event
    assign clr_ok = ~break_state | break_clear_en;
    assign fallback = stop_mode & ctrl_r.base_clk_sel;

    always_comb begin
        ctrl_nxt = ctrl_r;
        auto_nxt = auto_r;
        settled_prev_nxt = settled_s;
        // flag clear first, so a lock change in the same cycle wins
        if (ctrl_touch && clr_ok) begin
            ctrl_nxt.lock_change_flag = 1'b0;
        end
        if (auto_r && lock_edge) begin
            ctrl_nxt.lock_change_flag = 1'b1;
        end
        if (!auto_r) begin
            ctrl_nxt.lock_change_flag = 1'b0;
        end
        if (wr_hit && avs_address == PCM_OFF_PLL_CTRL) begin
            ctrl_nxt.lock_irq_enable = avs_writedata[PCM_CTL_IRQ_EN_BIT];
            // pll cannot be switched off while it drives the base clock
            ctrl_nxt.pll_enable = avs_writedata[PCM_CTL_PLL_EN_BIT] | ctrl_r.base_clk_sel;
            // vco select needs the pll on, but no lock is demanded
            ctrl_nxt.base_clk_sel = avs_writedata[PCM_CTL_BCS_BIT] & ctrl_r.pll_enable;
        end
        if (wr_hit && avs_address == PCM_OFF_BW_CTRL) begin
            auto_nxt = avs_writedata[PCM_BW_AUTO_BIT];
        end
        if (stop_mode) begin
            ctrl_nxt.base_clk_sel = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= PCM_CTRL_RST;
            auto_r <= PCM_AUTO_RST;
            settled_prev_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            auto_r <= auto_nxt;
            settled_prev_r <= settled_prev_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky event status, write-one clear, enable

    always_comb begin
        ev_set = '0;
        ev_set[PCM_EV_LOCK_BIT] = auto_r & lock_edge;
        ev_set[PCM_EV_FALLBACK_BIT] = fallback;
        ev_stat_nxt = ev_stat_r;
        ev_en_nxt = ev_en_r;
        if (wr_hit && avs_address == PCM_OFF_IRQ_CLR) begin
            ev_stat_nxt = ev_stat_r & ~avs_writedata[PCM_EV_W-1:0];
        end
        // set wins over a clear in the same cycle
        ev_stat_nxt = ev_stat_nxt | ev_set;
        if (!auto_r) begin
            ev_stat_nxt[PCM_EV_LOCK_BIT] = 1'b0;
        end
        if (wr_hit && avs_address == PCM_OFF_IRQ_EN) begin
            ev_en_nxt = avs_writedata[PCM_EV_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_stat_r <= PCM_EV_RST;
            ev_en_r <= PCM_EV_RST;
        end else begin
            ev_stat_r <= ev_stat_nxt;
            ev_en_r <= ev_en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock mode: wait mode has no input here, so nothing changes in it

    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            PCM_MODE_OSC: begin
                if (stop_mode) begin
                    mode_nxt = stop_osc_keep ? PCM_MODE_KEEP : PCM_MODE_HALT;
                end else if (ctrl_r.base_clk_sel) begin
                    mode_nxt = PCM_MODE_VCO;
                end
            end
            PCM_MODE_VCO: begin
                if (stop_mode) begin
                    mode_nxt = stop_osc_keep ? PCM_MODE_KEEP : PCM_MODE_HALT;
                end else if (!ctrl_r.base_clk_sel) begin
                    mode_nxt = PCM_MODE_OSC;
                end
            end
            PCM_MODE_KEEP: begin
                if (!stop_mode) begin
                    mode_nxt = PCM_MODE_OSC;
                end else if (!stop_osc_keep) begin
                    mode_nxt = PCM_MODE_HALT;
                end
            end
            PCM_MODE_HALT: begin
                if (!stop_mode) begin
                    mode_nxt = PCM_MODE_OSC;
                end else if (stop_osc_keep) begin
                    mode_nxt = PCM_MODE_KEEP;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= PCM_MODE_OSC;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs: halved base clock, run enables, interrupt level

    always_comb begin
        vco_prev_nxt = vco_s;
        clk_half_nxt = clk_half_r;
        unique case (mode_r)
            PCM_MODE_OSC, PCM_MODE_KEEP: begin
                clk_half_nxt = ~clk_half_r;
            end
            PCM_MODE_VCO: begin
                if (vco_s && !vco_prev_r) begin
                    clk_half_nxt = ~clk_half_r;
                end
            end
            PCM_MODE_HALT: begin
                clk_half_nxt = 1'b0;
            end
        endcase
        osc_run_nxt = (mode_nxt != PCM_MODE_HALT);
        pll_run_nxt = ctrl_nxt.pll_enable & ~stop_mode;
        irq_nxt = ((ctrl_nxt.lock_irq_enable & ctrl_nxt.lock_change_flag & auto_nxt)
            | (|(ev_stat_nxt & ev_en_nxt))) & (mode_nxt != PCM_MODE_HALT);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vco_prev_r <= 1'b0;
            clk_half_r <= 1'b0;
            osc_run_r <= 1'b1;
            pll_run_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            vco_prev_r <= vco_prev_nxt;
            clk_half_r <= clk_half_nxt;
            osc_run_r <= osc_run_nxt;
            pll_run_r <= pll_run_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign base_clk_out = clk_half_r;
    assign osc_run = osc_run_r;
    assign pll_run = pll_run_r;
    assign clkgen_irq_out = irq_r;

endmodule // pcm_ctrl

// ===== shared/pcm_pkg.sv
// package of constants and types for the pll clock mode control block
package pcm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int PCM_ADDR_W = 5;
    localparam int PCM_DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [PCM_ADDR_W-1:0] PCM_OFF_PLL_CTRL = 5'h00;
    localparam logic [PCM_ADDR_W-1:0] PCM_OFF_BW_CTRL = 5'h04;
    localparam logic [PCM_ADDR_W-1:0] PCM_OFF_IRQ_STAT = 5'h08;
    localparam logic [PCM_ADDR_W-1:0] PCM_OFF_IRQ_CLR = 5'h0C;
    localparam logic [PCM_ADDR_W-1:0] PCM_OFF_IRQ_EN = 5'h10;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int PCM_CTL_IRQ_EN_BIT = 7;
    localparam int PCM_CTL_FLAG_BIT = 6;
    localparam int PCM_CTL_PLL_EN_BIT = 5;
    localparam int PCM_CTL_BCS_BIT = 4;
    localparam int PCM_BW_AUTO_BIT = 7;
    localparam int PCM_BW_SETTLED_BIT = 6;
    localparam int PCM_EV_W = 2;
    localparam int PCM_EV_LOCK_BIT = 0;
    localparam int PCM_EV_FALLBACK_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////
    // types and reset values
    typedef struct packed {
        logic lock_irq_enable;
        logic lock_change_flag;
        logic pll_enable;
        logic base_clk_sel;
    } pcm_ctrl_s;

    localparam pcm_ctrl_s PCM_CTRL_RST = '{1'b0, 1'b0, 1'b1, 1'b0};
    localparam logic PCM_AUTO_RST = 1'b0;
    localparam logic [PCM_EV_W-1:0] PCM_EV_RST = 2'h0;

    typedef enum logic [1:0] {
        PCM_MODE_OSC = 2'b00,
        PCM_MODE_VCO = 2'b01,
        PCM_MODE_KEEP = 2'b11,
        PCM_MODE_HALT = 2'b10
    } pcm_mode_e;

endpackage

// ===== rtl/pcm_sync2.sv
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module pcm_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    initial begin
        if (WIDTH < 1) begin
            $error("pcm_sync2: WIDTH must be at least 1");
        end
    end

    // first stage is read by the second stage only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // pcm_sync2

// ===== tb/pcm_ctrl_sva.sv
// port-level checker of the pll clock mode control block
`timescale 1ns/1ps
module pcm_ctrl_sva
    import pcm_pkg::*;
#(
    parameter int ADDR_W = PCM_ADDR_W,
    parameter int DATA_W = PCM_DATA_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    // system module
    input wire logic stop_mode,
    input wire logic stop_osc_keep,
    input wire logic break_state,
    input wire logic break_clear_en,
    // analog pll pins
    input wire logic freq_settled_pin,
    input wire logic divided_vco_clk,
    // clock generator outputs
    input wire logic osc_run,
    input wire logic pll_run,
    input wire logic base_clk_out,
    input wire logic clkgen_irq_out
);
    ////////////////////////////////////////////////////////////////////////////
    // shadow of the few register bits the properties depend on
    logic wr_done, rd_ctl, rd_bw, auto_r, auto_nxt, stp_r, stp_nxt;
    logic [1:0] ien_r, ien_nxt;
    always_comb begin
        wr_done = avs_write && !avs_waitrequest;
        rd_ctl = avs_read && !avs_waitrequest && avs_address == ADDR_W'(PCM_OFF_PLL_CTRL);
        rd_bw = avs_read && !avs_waitrequest && avs_address == ADDR_W'(PCM_OFF_BW_CTRL);
        auto_nxt = auto_r;
        ien_nxt = ien_r;
        stp_nxt = stp_r;
        if (wr_done && avs_address == ADDR_W'(PCM_OFF_BW_CTRL)) begin
            auto_nxt = avs_writedata[PCM_BW_AUTO_BIT];
        end
        if (wr_done && avs_address == ADDR_W'(PCM_OFF_IRQ_EN)) begin
            ien_nxt = avs_writedata[1:0];
        end
        // any control write may reselect the vco, so the stop memory ends there
        if (stop_mode) begin
            stp_nxt = 1'b1;
        end else if (wr_done && avs_address == ADDR_W'(PCM_OFF_PLL_CTRL)) begin
            stp_nxt = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_r <= PCM_AUTO_RST;
            ien_r <= 2'h0;
            stp_r <= 1'b0;
        end else begin
            auto_r <= auto_nxt;
            ien_r <= ien_nxt;
            stp_r <= stp_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pll_stop_off: assert property (stop_mode |=> !pll_run)
        else $error("pll_run high after stop");
    a_halt_outs_low: assert property ((stop_mode && !stop_osc_keep)[*4] |->
        !osc_run && !base_clk_out && !clkgen_irq_out) else $error("outputs active in halt");
    a_keep_osc_run: assert property ((stop_mode && stop_osc_keep)[*4] |-> osc_run)
        else $error("oscillator stopped in keep stop");
    a_sel_stays_clr: assert property (stp_r && $past(stp_r) && rd_ctl |->
        !avs_readdata[PCM_CTL_BCS_BIT]) else $error("clock select set after stop");
    a_osc_half_tog: assert property ((!stop_mode)[*4] ##0 stp_r |->
        base_clk_out != $past(base_clk_out)) else $error("output clock not osc half");
    a_flag_man_zero: assert property (!auto_r && !$past(auto_r) && rd_ctl |->
        !avs_readdata[PCM_CTL_FLAG_BIT]) else $error("flag read set in manual mode");
    a_lock_man_zero: assert property (!auto_r && !$past(auto_r) && rd_bw |->
        !avs_readdata[PCM_BW_SETTLED_BIT]) else $error("settled read set in manual mode");
    a_irq_man_quiet: assert property (!auto_r && ien_r == 2'h0 |-> !clkgen_irq_out)
        else $error("interrupt in manual mode");
endmodule // pcm_ctrl_sva

bind pcm_ctrl pcm_ctrl_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_pcm_ctrl_sva (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode), .stop_osc_keep(stop_osc_keep),
    .break_state(break_state), .break_clear_en(break_clear_en),
    .freq_settled_pin(freq_settled_pin), .divided_vco_clk(divided_vco_clk),
    .osc_run(osc_run), .pll_run(pll_run), .base_clk_out(base_clk_out),
    .clkgen_irq_out(clkgen_irq_out));

// ===== tb/pcm_ctrl_tb_top.sv
// self-checking bench of the pll clock mode control block
`timescale 1ns/1ps
module pcm_ctrl_tb_top
    import pcm_pkg::*;
;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, stop_mode, stop_osc_keep;
    logic break_state, break_clear_en, freq_settled_pin, divided_vco_clk;
    logic osc_run, pll_run, base_clk_out, clkgen_irq_out;
    logic [PCM_ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:0] seed;
    logic [2:0] vdiv;
    int errors, n_checks, cyc;

    pcm_ctrl u_pcm_ctrl (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .stop_mode(stop_mode), .stop_osc_keep(stop_osc_keep), .break_state(break_state),
        .break_clear_en(break_clear_en), .freq_settled_pin(freq_settled_pin),
        .divided_vco_clk(divided_vco_clk), .osc_run(osc_run), .pll_run(pll_run),
        .base_clk_out(base_clk_out), .clkgen_irq_out(clkgen_irq_out));

    ////////////////////////////////////////////////////////////////////////////
    // clock, vco stand-in at clk/8, timeout
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        vdiv <= vdiv + 3'h1;
        divided_vco_clk <= vdiv[2];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic [31:0] ctl(input logic ie, input logic fl, input logic pe,
                                        input logic bs);
        return 32'({ie, fl, pe, bs}) << PCM_CTL_BCS_BIT;
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // entered just after a rising edge; one idle edge follows so strobes never re-rise at once
    task automatic bus(input logic w, input logic [PCM_ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                errors++;
                end_sim();
            end
            @(posedge clk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input string nm, input logic [PCM_ADDR_W-1:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic irqc(input logic e);
        @(negedge clk);
        chk("irq", 32'(e), 32'(clkgen_irq_out));
        @(posedge clk);
    endtask
    // counts output clock edges over sixteen cycles
    task automatic togc(input int e);
        int n;
        logic b;
        n = 0;
        @(negedge clk);
        b = base_clk_out;
        repeat (16) begin
            @(negedge clk);
            if (base_clk_out !== b) n++;
            b = base_clk_out;
        end
        chk("toggles", 32'(e), 32'(n));
        @(posedge clk);
    endtask
    task automatic pin(input logic v);
        freq_settled_pin <= v;
        repeat (6) @(posedge clk);
    endtask
    task automatic end_sim;
        if (errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = '0;
        avs_writedata = '0; stop_mode = 1'b0; stop_osc_keep = 1'b0; break_state = 1'b0;
        break_clear_en = 1'b0; freq_settled_pin = 1'b0; divided_vco_clk = 1'b0;
        vdiv = 3'h0; errors = 0; n_checks = 0; cyc = 0; seed = 8'h4E; q = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc("ctrl", PCM_OFF_PLL_CTRL, 32'(PCM_CTRL_RST) << PCM_CTL_BCS_BIT);
        rdc("bw", PCM_OFF_BW_CTRL, 32'h0);
        rdc("stat", PCM_OFF_IRQ_STAT, 32'h0);
        rdc("en", PCM_OFF_IRQ_EN, 32'h0);
        bus(1'b1, 5'h14, 32'hFF);
        rdc("unmapped", 5'h14, 32'h0);
        togc(16);
        pin(1'b1);
        rdc("ctrl", PCM_OFF_PLL_CTRL, ctl(0, 0, 1, 0));
        rdc("bw", PCM_OFF_BW_CTRL, 32'h0);
        irqc(1'b0);
        bus(1'b1, PCM_OFF_BW_CTRL, 32'h80);
        rdc("bw", PCM_OFF_BW_CTRL, 32'hC0);
        pin(1'b0);
        irqc(1'b0);
        rdc("ctrl", PCM_OFF_PLL_CTRL, ctl(0, 1, 1, 0));
        rdc("ctrl", PCM_OFF_PLL_CTRL, ctl(0, 0, 1, 0));
        bus(1'b1, PCM_OFF_PLL_CTRL, ctl(1, 0, 1, 0));
        pin(1'b1);
        irqc(1'b1);
        rdc("bw", PCM_OFF_BW_CTRL, 32'hC0);
        rdc("ctrl", PCM_OFF_PLL_CTRL, ctl(1, 1, 1, 0));
        irqc(1'b0);
        // break: protected, then clearable
        bus(1'b1, PCM_OFF_PLL_CTRL, ctl(0, 0, 1, 0));
        pin(1'b0);
        break_state <= 1'b1;
        rdc("ctrl", PCM_OFF_PLL_CTRL, ctl(0, 1, 1, 0));
        bus(1'b1, PCM_OFF_PLL_CTRL, ctl(0, 0, 1, 0));
        rdc("ctrl", PCM_OFF_PLL_CTRL, ctl(0, 1, 1, 0));
        break_clear_en <= 1'b1;
        rdc("ctrl", PCM_OFF_PLL_CTRL, ctl(0, 1, 1, 0));
        rdc("ctrl", PCM_OFF_PLL_CTRL, ctl(0, 0, 1, 0));
        break_state <= 1'b0;
        rdc("ctrl", PCM_OFF_PLL_CTRL, ctl(0, 0, 1, 0));
        // status raised, masked, enabled, cleared
        rdc("stat", PCM_OFF_IRQ_STAT, 32'h1);
        irqc(1'b0);
        bus(1'b1, PCM_OFF_IRQ_EN, 32'h1);
        irqc(1'b1);
        bus(1'b1, PCM_OFF_IRQ_CLR, 32'h1);
        rdc("stat", PCM_OFF_IRQ_STAT, 32'h0);
        irqc(1'b0);
        repeat (6) begin
            seed = lfsr(seed);
            bus(1'b1, PCM_OFF_IRQ_EN, {24'h0, seed});
            rdc("en", PCM_OFF_IRQ_EN, {30'h0, seed[1:0]});
        end
        bus(1'b1, PCM_OFF_IRQ_EN, 32'h2);
        // vco selected while unsettled, then stop with oscillator off
        bus(1'b1, PCM_OFF_PLL_CTRL, ctl(0, 0, 1, 1));
        rdc("ctrl", PCM_OFF_PLL_CTRL, ctl(0, 0, 1, 1));
        togc(2);
        stop_mode <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("osc_run", 32'h0, 32'(osc_run));
        chk("pll_run", 32'h0, 32'(pll_run));
        chk("clk_out", 32'h0, 32'(base_clk_out));
        chk("irq", 32'h0, 32'(clkgen_irq_out));
        @(posedge clk);
        stop_mode <= 1'b0;
        repeat (4) @(posedge clk);
        irqc(1'b1);
        rdc("ctrl", PCM_OFF_PLL_CTRL, ctl(0, 0, 1, 0));
        rdc("stat", PCM_OFF_IRQ_STAT, 32'h2);
        togc(16);
        bus(1'b1, PCM_OFF_IRQ_CLR, 32'h2);
        pin(1'b1);
        rdc("bw", PCM_OFF_BW_CTRL, 32'hC0);
        // stop with oscillator kept running
        bus(1'b1, PCM_OFF_PLL_CTRL, ctl(0, 0, 1, 1));
        stop_osc_keep <= 1'b1;
        stop_mode <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("osc_run", 32'h1, 32'(osc_run));
        chk("pll_run", 32'h0, 32'(pll_run));
        @(posedge clk);
        stop_mode <= 1'b0;
        repeat (4) @(posedge clk);
        rdc("ctrl", PCM_OFF_PLL_CTRL, ctl(0, 0, 1, 0));
        // clock select is already clear, so the pll may be switched off before the last toggle count
        bus(1'b1, PCM_OFF_PLL_CTRL, ctl(0, 0, 0, 0));
        @(negedge clk);
        chk("pll_run", 32'h0, 32'(pll_run));
        @(posedge clk);
        togc(16);
        end_sim();
    end
endmodule // pcm_ctrl_tb_top
